// >>> hw/rpm_map.vh
// Register offsets, field positions, reset values and timing counts of the port monitor
`ifndef RPM_MAP_VH
`define RPM_MAP_VH

// Register offsets
`define RPM_OFS_PORT_SEL 8'h4c
`define RPM_OFS_LINE_LENGTH_HIGH_FIELD 8'h75
`define RPM_OFS_LINE_LENGTH_LOW_FIELD 8'h76
`define RPM_OFS_FREQ_CTL 8'h77
`define RPM_OFS_SCRATCH_A 8'h78
`define RPM_OFS_SCRATCH_B 8'h79
`define RPM_OFS_ERR_FLAGS 8'h7a
`define RPM_OFS_ERR_TALLY 8'h7b

// Reset values
`define RPM_RST_PORT_SEL 2'h0
`define RPM_RST_FREQ_CTL 8'hc5
`define RPM_RST_SCRATCH_A 8'h00
`define RPM_RST_SCRATCH_B 8'h01

// Field positions of the frequency detect control register
`define RPM_FD_HYST_HI 7
`define RPM_FD_HYST_LO 6
`define RPM_FD_STAB_HI 5
`define RPM_FD_STAB_LO 4
`define RPM_FD_LOTHR_HI 3
`define RPM_FD_LOTHR_LO 0

// Field positions of the error flag register
`define RPM_EF_LENGTH 3
`define RPM_EF_CKSUM 2
`define RPM_EF_ECC2 1
`define RPM_EF_ECC1 0

// Stability times in ns and the clock period in ns
`define RPM_CLK_NS 100
`define RPM_STAB0_NS 40000
`define RPM_STAB1_NS 80000
`define RPM_STAB2_NS 320000
`define RPM_STAB3_NS 1280000

// Least times round up to whole cycles
`define RPM_STAB0_CYC ((`RPM_STAB0_NS + `RPM_CLK_NS - 1) / `RPM_CLK_NS)
`define RPM_STAB1_CYC ((`RPM_STAB1_NS + `RPM_CLK_NS - 1) / `RPM_CLK_NS)
`define RPM_STAB2_CYC ((`RPM_STAB2_NS + `RPM_CLK_NS - 1) / `RPM_CLK_NS)
`define RPM_STAB3_CYC ((`RPM_STAB3_NS + `RPM_CLK_NS - 1) / `RPM_CLK_NS)

`endif

// >>> hw/rpm_port_monitor.v
// Per receive port monitor and status register group with port selection
`timescale 1ns/1ps
`include "rpm_map.vh"

//////////////////////////////////////////////////////////////////////////////////////////////////
module rpm_port_monitor #(
   parameter NUM_PORTS = 4,
   parameter STAB3_CYC = `RPM_STAB3_CYC
) (
   // Clock and reset
   input wire mclk,
   input wire rst,
   // Register port from the serial control slave
   input wire [7:0] reg_addr,
   input wire [7:0] reg_wdata,
   input wire reg_wr,
   input wire reg_rd,
   output wire [7:0] reg_rdata,
   output wire [1:0] port_select,
   // Line length measurement per port
   input wire [NUM_PORTS*16-1:0] line_len_meas,
   input wire [NUM_PORTS-1:0] line_len_vld,
   input wire [NUM_PORTS-1:0] line_length_change_irq_enable,
   // Link clock frequency measurement per port, in MHz
   input wire [NUM_PORTS*8-1:0] freq_meas,
   input wire [NUM_PORTS-1:0] freq_meas_vld,
   output wire [NUM_PORTS*8-1:0] freq_current,
   output wire [NUM_PORTS-1:0] freq_stable,
   output wire [NUM_PORTS-1:0] no_link_clock_status,
   // Packet error events per port, one pulse per errored packet
   input wire [NUM_PORTS-1:0] pkt_length_err,
   input wire [NUM_PORTS-1:0] pkt_checksum_err,
   input wire [NUM_PORTS-1:0] hdr_multibit_err,
   input wire [NUM_PORTS-1:0] hdr_singlebit_err
);

   //////////////////////////////////////////////////////////////////////////////////////////////
   // Constants and helper functions

   // Stability counts held at 32 bits, sliced to the timer width below
   localparam [31:0] STAB0_W = `RPM_STAB0_CYC;
   localparam [31:0] STAB1_W = `RPM_STAB1_CYC;
   localparam [31:0] STAB2_W = `RPM_STAB2_CYC;
   localparam [31:0] STAB3_W = STAB3_CYC;

   // Cycle count for a stability code
   function [13:0] stab_cycles;
      input [1:0] code;
      begin
         case (code)
            2'h0: stab_cycles = STAB0_W[13:0];
            2'h1: stab_cycles = STAB1_W[13:0];
            2'h2: stab_cycles = STAB2_W[13:0];
            default: stab_cycles = STAB3_W[13:0];
         endcase
      end
   endfunction

   // Absolute difference of two frequency readings
   function [7:0] abs_diff;
      input [7:0] a;
      input [7:0] b;
      begin
         abs_diff = (a > b) ? (a - b) : (b - a);
      end
   endfunction

   // Byte of the selected port from a packed per-port view
   function [7:0] pick_byte;
      input [NUM_PORTS*8-1:0] view;
      input [1:0] s;
      begin
         pick_byte = view[s*8 +: 8];
      end
   endfunction

   // Strobe aimed at one register of the selected port
   function port_hit;
      input strobe;
      input sel;
      input [7:0] addr;
      input [7:0] ofs;
      begin
         port_hit = strobe && sel && (addr == ofs);
      end
   endfunction

   //////////////////////////////////////////////////////////////////////////////////////////////
   // Port selection and access decode

   reg [1:0] port_sel_r;
   reg [7:0] rdata_r;
   wire [NUM_PORTS*8-1:0] v_line_hi;
   wire [NUM_PORTS*8-1:0] v_line_lo;
   wire [NUM_PORTS*8-1:0] v_ctl;
   wire [NUM_PORTS*8-1:0] v_mba;
   wire [NUM_PORTS*8-1:0] v_mbb;
   wire [NUM_PORTS*8-1:0] v_flags;
   wire [NUM_PORTS*8-1:0] v_tally;

   // Selection register written by the host before per-port accesses
   always @(posedge mclk) begin
      if (rst) begin
         port_sel_r <= `RPM_RST_PORT_SEL;
      end else if (reg_wr && reg_addr == `RPM_OFS_PORT_SEL) begin
         port_sel_r <= reg_wdata[1:0];
      end
   end

   // Read data registered one cycle after the read strobe
   always @(posedge mclk) begin
      if (rst) begin
         rdata_r <= 8'h00;
      end else if (reg_rd) begin
         case (reg_addr)
            `RPM_OFS_PORT_SEL: rdata_r <= {6'h00, port_sel_r};
            `RPM_OFS_LINE_LENGTH_HIGH_FIELD: rdata_r <= pick_byte(v_line_hi, port_sel_r);
            `RPM_OFS_LINE_LENGTH_LOW_FIELD: rdata_r <= pick_byte(v_line_lo, port_sel_r);
            `RPM_OFS_FREQ_CTL: rdata_r <= pick_byte(v_ctl, port_sel_r);
            `RPM_OFS_SCRATCH_A: rdata_r <= pick_byte(v_mba, port_sel_r);
            `RPM_OFS_SCRATCH_B: rdata_r <= pick_byte(v_mbb, port_sel_r);
            `RPM_OFS_ERR_FLAGS: rdata_r <= pick_byte(v_flags, port_sel_r);
            `RPM_OFS_ERR_TALLY: rdata_r <= pick_byte(v_tally, port_sel_r);
            default: rdata_r <= 8'h00;
         endcase
      end
   end

   // Registered read data and selection, straight from flops
   assign reg_rdata = rdata_r;
   assign port_select = port_sel_r;

   //////////////////////////////////////////////////////////////////////////////////////////////
   // Per-port copies

   // One copy of every per-port register for each receive port
   genvar p;
   generate
      for (p = 0; p < NUM_PORTS; p = p + 1) begin : g_port
         localparam [31:0] PNUM = p;

         // Access strobes of this port
         wire sel = (port_sel_r == PNUM[1:0]);
         wire rd_hi = port_hit(reg_rd, sel, reg_addr, `RPM_OFS_LINE_LENGTH_HIGH_FIELD);
         wire rd_lo = port_hit(reg_rd, sel, reg_addr, `RPM_OFS_LINE_LENGTH_LOW_FIELD);
         wire rd_flags = port_hit(reg_rd, sel, reg_addr, `RPM_OFS_ERR_FLAGS);
         wire rd_tally = port_hit(reg_rd, sel, reg_addr, `RPM_OFS_ERR_TALLY);
         wire wr_ctl = port_hit(reg_wr, sel, reg_addr, `RPM_OFS_FREQ_CTL);
         wire wr_mba = port_hit(reg_wr, sel, reg_addr, `RPM_OFS_SCRATCH_A);
         wire wr_mbb = port_hit(reg_wr, sel, reg_addr, `RPM_OFS_SCRATCH_B);

         // Error events of one packet, all pulsed in the same cycle
         wire [3:0] evt = {pkt_length_err[p], pkt_checksum_err[p],
                           hdr_multibit_err[p], hdr_singlebit_err[p]};
         wire [7:0] f_in = freq_meas[p*8 +: 8];

         // Registers of this port
         reg [15:0] line_len_r;
         reg frozen_r;
         reg [7:0] hold_lo_r;
         reg hold_vld_r;
         reg [7:0] ctl_r;
         reg [7:0] mba_r;
         reg [7:0] mbb_r;
         reg [3:0] flags_r;
         reg [7:0] tally_r;
         reg [7:0] fcur_r;
         reg [13:0] stab_cnt_r;
         reg stable_r;
         reg nolink_r;

         // Capture rule and stability target of the frequency tracker
         wire f_cap = freq_meas_vld[p] &&
            (abs_diff(f_in, fcur_r) > {6'h00, ctl_r[`RPM_FD_HYST_HI:`RPM_FD_HYST_LO]});
         wire [13:0] stab_need = stab_cycles(ctl_r[`RPM_FD_STAB_HI:`RPM_FD_STAB_LO]);

         // Next flag value, a new event beats the clearing read
         wire [3:0] flags_nxt = (rd_flags ? 4'h0 : flags_r) | evt;

         // Line length capture, frozen after an update until the low byte is read
         always @(posedge mclk) begin
            if (rst) begin
               line_len_r <= 16'h0000;
               frozen_r <= 1'b0;
            end else begin
               if (line_len_vld[p] && !(line_length_change_irq_enable[p] && frozen_r)) begin
                  line_len_r <= line_len_meas[p*16 +: 16];
                  frozen_r <= line_length_change_irq_enable[p];
               end else if (rd_lo || !line_length_change_irq_enable[p]) begin
                  frozen_r <= 1'b0;
               end
            end
         end

         // High byte read latches the matching low byte for the next low read
         always @(posedge mclk) begin
            if (rst) begin
               hold_lo_r <= 8'h00;
               hold_vld_r <= 1'b0;
            end else if (rd_hi) begin
               hold_lo_r <= line_len_r[7:0];
               hold_vld_r <= 1'b1;
            end else if (rd_lo) begin
               hold_vld_r <= 1'b0;
            end
         end

         // Host writable control and scratch registers
         always @(posedge mclk) begin
            if (rst) begin
               ctl_r <= `RPM_RST_FREQ_CTL;
               mba_r <= `RPM_RST_SCRATCH_A;
               mbb_r <= `RPM_RST_SCRATCH_B;
            end else begin
               if (wr_ctl) begin
                  ctl_r <= reg_wdata;
               end
               if (wr_mba) begin
                  mba_r <= reg_wdata;
               end
               if (wr_mbb) begin
                  mbb_r <= reg_wdata;
               end
            end
         end

         // Frequency tracking with hysteresis and stability timing
         always @(posedge mclk) begin
            if (rst) begin
               fcur_r <= 8'h00;
               stab_cnt_r <= 14'h0000;
               stable_r <= 1'b0;
            end else if (f_cap) begin
               fcur_r <= f_in;
               stab_cnt_r <= 14'h0000;
               stable_r <= 1'b0;
            end else if (stab_cnt_r >= stab_need) begin
               stable_r <= 1'b1;
            end else begin
               stab_cnt_r <= stab_cnt_r + 14'h0001;
            end
         end

         // Low clock indication from the tracked frequency
         always @(posedge mclk) begin
            if (rst) begin
               nolink_r <= 1'b1;
            end else begin
               nolink_r <= fcur_r < {4'h0, ctl_r[`RPM_FD_LOTHR_HI:`RPM_FD_LOTHR_LO]};
            end
         end

         // Sticky error flags, a new event beats the clearing read
         always @(posedge mclk) begin
            if (rst) begin
               flags_r <= 4'h0;
            end else begin
               flags_r <= flags_nxt;
            end
         end

         // Errored packet tally, once per packet, saturating, restarted by a read
         always @(posedge mclk) begin
            if (rst) begin
               tally_r <= 8'h00;
            end else if (rd_tally) begin
               tally_r <= {7'h00, |evt};
            end else if (|evt && tally_r != 8'hff) begin
               tally_r <= tally_r + 8'h01;
            end
         end

         // Views for the read multiplexer and status outputs
         assign v_line_hi[p*8 +: 8] = line_len_r[15:8];
         assign v_line_lo[p*8 +: 8] = hold_vld_r ? hold_lo_r : line_len_r[7:0];
         assign v_ctl[p*8 +: 8] = ctl_r;
         assign v_mba[p*8 +: 8] = mba_r;
         assign v_mbb[p*8 +: 8] = mbb_r;
         assign v_flags[p*8 +: 8] = {4'h0, flags_r};
         assign v_tally[p*8 +: 8] = tally_r;
         assign freq_current[p*8 +: 8] = fcur_r;
         assign freq_stable[p] = stable_r;
         assign no_link_clock_status[p] = nolink_r;
      end
   endgenerate

endmodule

// >>> tb/rpm_host_model.sv
// Host side model that issues single register accesses
`timescale 1ns/1ps
module rpm_host_model (
   // Clock
   input wire mclk,
   // Register port
   output reg [7:0] reg_addr,
   output reg [7:0] reg_wdata,
   output reg reg_wr,
   output reg reg_rd,
   input wire [7:0] reg_rdata
);
   // Idle port at time zero
   initial begin
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
   end
   // Write taken one edge after the strobe rises; lines scrambled after
   task wr(input [7:0] a, input [7:0] v);
      begin
         @(posedge mclk);
         reg_addr <= a;
         reg_wdata <= v;
         reg_wr <= 1'b1;
         @(posedge mclk);
         reg_wr <= 1'b0;
         reg_addr <= ~a;
         reg_wdata <= ~v;
      end
   endtask
   // Read taken one edge after the strobe rises; data sampled just after
   task rd(input [7:0] a, output [7:0] v);
      begin
         @(posedge mclk);
         reg_addr <= a;
         reg_rd <= 1'b1;
         @(posedge mclk);
         reg_rd <= 1'b0;
         reg_addr <= ~a;
         #1 v = reg_rdata;
      end
   endtask
endmodule

// >>> tb/rpm_port_monitor_asserts.sv
// Checker of the register port and port zero monitor behaviour
`timescale 1ns/1ps
module rpm_port_monitor_asserts #(parameter NUM_PORTS = 4, parameter STAB3_CYC = 40) (
   // Clock, reset and register port
   input wire mclk,
   input wire rst,
   input wire [7:0] reg_addr,
   input wire [7:0] reg_wdata,
   input wire reg_wr,
   input wire reg_rd,
   input wire [7:0] reg_rdata,
   input wire [1:0] port_select,
   // Monitor signals
   input wire [NUM_PORTS*8-1:0] freq_meas,
   input wire [NUM_PORTS-1:0] freq_meas_vld,
   input wire [NUM_PORTS*8-1:0] freq_current,
   input wire [NUM_PORTS-1:0] freq_stable,
   input wire [NUM_PORTS-1:0] pkt_length_err,
   input wire [NUM_PORTS-1:0] pkt_checksum_err,
   input wire [NUM_PORTS-1:0] hdr_multibit_err,
   input wire [NUM_PORTS-1:0] hdr_singlebit_err
);
   default clocking @(posedge mclk); endclocking
   default disable iff (rst);
   // Port zero slices and any error on the selected port
   wire [1:0] wsel = reg_wdata[1:0];
   wire [7:0] f0 = freq_current[7:0];
   wire [7:0] m0 = freq_meas[7:0];
   wire v0 = freq_meas_vld[0];
   wire s0 = freq_stable[0];
   wire se = pkt_length_err[port_select] | pkt_checksum_err[port_select]
      | hdr_multibit_err[port_select] | hdr_singlebit_err[port_select];
   sel_follow_a: assert property (reg_wr && reg_addr == 8'h4c |=> port_select == $past(wsel))
      else $error("port select missed a write");
   sel_hold_a: assert property (!(reg_wr && reg_addr == 8'h4c) |=> $stable(port_select))
      else $error("port select moved without a write");
   unmapped_zero_a: assert property (reg_rd && reg_addr == 8'h00 |=> reg_rdata == 8'h00)
      else $error("unmapped read not zero");
   rdata_hold_a: assert property (!reg_rd |=> $stable(reg_rdata))
      else $error("read data moved without a read");
   tally_restart_a: assert property (reg_rd && reg_addr == 8'h7b && !se ##1 !se && !reg_wr
      ##1 reg_rd && reg_addr == 8'h7b |=> reg_rdata == 8'h00)
      else $error("tally not restarted by read");
   flags_clear_a: assert property (reg_rd && reg_addr == 8'h7a && !se ##1 !se && !reg_wr
      ##1 reg_rd && reg_addr == 8'h7a |=> reg_rdata == 8'h00)
      else $error("flags not cleared by read");
   freq_capture_a: assert property ($changed(f0) |-> $past(v0) && f0 == $past(m0))
      else $error("frequency changed without a measurement");
   stable_drop_a: assert property ($fell(s0) |-> $changed(f0))
      else $error("stable fell without a capture");
   stable_wait_a: assert property ($changed(f0) |-> !s0 [*8])
      else $error("stable too soon after capture");
endmodule
bind rpm_port_monitor rpm_port_monitor_asserts #(.NUM_PORTS(NUM_PORTS), .STAB3_CYC(STAB3_CYC))
   rpm_port_monitor_asserts_inst (.mclk(mclk), .rst(rst), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
   .port_select(port_select), .freq_meas(freq_meas), .freq_meas_vld(freq_meas_vld),
   .freq_current(freq_current), .freq_stable(freq_stable), .pkt_length_err(pkt_length_err),
   .pkt_checksum_err(pkt_checksum_err), .hdr_multibit_err(hdr_multibit_err),
   .hdr_singlebit_err(hdr_singlebit_err));

// >>> tb/rpm_port_monitor_test.sv
// Testbench of the port monitor register group
`timescale 1ns/1ps
module rpm_port_monitor_test;
`define CHK(n, e, g) begin checks = checks + 1; if ((g) !== (e)) begin \
   bad_count = bad_count + 1; $display("[ERR] %0s exp %h got %h", n, e, g); end end
   reg mclk = 1'b0;
   reg rst = 1'b1;
   reg [63:0] len = 64'h0;
   reg [31:0] fm = 32'h0;
   reg [3:0] lv = 4'h0, frz = 4'h0, fv = 4'h0, el = 4'h0, ec = 4'h0, em = 4'h0, es = 4'h0;
   wire [7:0] addr, wdata, rdata;
   wire wr, rd;
   wire [1:0] psel;
   wire [31:0] fcur;
   wire [3:0] fst, nolk;
   reg [7:0] d;
   integer bad_count = 0, checks = 0;
   // Clock
   always #50 mclk = ~mclk;
   rpm_port_monitor #(.NUM_PORTS(4), .STAB3_CYC(40)) rpm_port_monitor_inst (.mclk(mclk),
      .rst(rst), .reg_addr(addr), .reg_wdata(wdata), .reg_wr(wr), .reg_rd(rd),
      .reg_rdata(rdata), .port_select(psel), .line_len_meas(len), .line_len_vld(lv),
      .line_length_change_irq_enable(frz), .freq_meas(fm), .freq_meas_vld(fv),
      .freq_current(fcur), .freq_stable(fst), .no_link_clock_status(nolk),
      .pkt_length_err(el), .pkt_checksum_err(ec), .hdr_multibit_err(em), .hdr_singlebit_err(es));
   rpm_host_model rpm_host_model_inst (.mclk(mclk), .reg_addr(addr), .reg_wdata(wdata),
      .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdata));
   // Access helpers and measurement pulses
   task w(input [7:0] a, input [7:0] v);
      rpm_host_model_inst.wr(a, v);
   endtask
   task rc(input [7:0] a, input [7:0] e);
      begin
         rpm_host_model_inst.rd(a, d);
         `CHK($sformatf("reg %h", a), e, d)
      end
   endtask
   task lenp(input [15:0] v, input f);
      begin
         @(posedge mclk);
         len[31:16] <= v;
         lv[1] <= 1'b1;
         frz[1] <= f;
         @(posedge mclk);
         lv[1] <= 1'b0;
      end
   endtask
   task fp(input [7:0] v);
      begin
         @(posedge mclk);
         fm[7:0] <= v;
         fv[0] <= 1'b1;
         @(posedge mclk);
         fv[0] <= 1'b0;
         @(posedge mclk);
         #1;
      end
   endtask
   task stab(input [7:0] c, input [7:0] f, input integer n);
      begin
         w(8'h77, c);
         fp(f);
         repeat (n - 10) @(posedge mclk);
         `CHK("stable", 1'b0, fst[0])
         repeat (15) @(posedge mclk);
         `CHK("stable", 1'b1, fst[0])
      end
   endtask
   task end_of_test;
      begin
         $display("checks %0d mismatches %0d", checks, bad_count);
         if (bad_count == 0 && checks > 0)
            $display("Testbench passed");
         else
            $display("Testbench failed");
         $finish;
      end
   endtask
   // Watchdog
   initial begin
      repeat (8000) @(posedge mclk);
      bad_count = bad_count + 1;
      end_of_test;
   end
   // Test sequence
   initial begin
      repeat (10) @(posedge mclk);
      rst <= 1'b0;
      rc(8'h76, 8'h00);
      rc(8'h77, 8'hc5);
      rc(8'h78, 8'h00);
      rc(8'h79, 8'h01);
      rc(8'h7a, 8'h00);
      rc(8'h7b, 8'h00);
      rc(8'h00, 8'h00);
      w(8'h4c, 8'h02);
      w(8'h78, 8'ha5);
      rc(8'h4c, 8'h02);
      `CHK("psel", 2'h2, psel)
      w(8'h4c, 8'h00);
      rc(8'h78, 8'h00);
      w(8'h4c, 8'h02);
      rc(8'h78, 8'ha5);
      $display("reset and scratch test done");
      w(8'h4c, 8'h01);
      lenp(16'h1234, 1'b0);
      rc(8'h76, 8'h34);
      lenp(16'h1111, 1'b1);
      lenp(16'h2222, 1'b1);
      rc(8'h76, 8'h11);
      lenp(16'h5566, 1'b0);
      rc(8'h75, 8'h55);
      lenp(16'h7788, 1'b0);
      rc(8'h76, 8'h66);
      $display("line length test done");
      w(8'h4c, 8'h00);
      w(8'h77, 8'hf5);
      fp(8'd20);
      `CHK("cur", 8'd20, fcur[7:0])
      `CHK("nolink", 1'b0, nolk[0])
      fp(8'd23);
      `CHK("cur", 8'd20, fcur[7:0])
      fp(8'd24);
      `CHK("cur", 8'd24, fcur[7:0])
      repeat (30) @(posedge mclk);
      `CHK("stable", 1'b0, fst[0])
      repeat (15) @(posedge mclk);
      `CHK("stable", 1'b1, fst[0])
      fp(8'd2);
      `CHK("nolink", 1'b1, nolk[0])
      `CHK("stable", 1'b0, fst[0])
      stab(8'hc5, 8'd40, 400);
      stab(8'hd5, 8'd60, 800);
      stab(8'he5, 8'd80, 3200);
      $display("frequency test done");
      w(8'h4c, 8'h03);
      @(posedge mclk);
      el[3] <= 1'b1;
      ec[3] <= 1'b1;
      @(posedge mclk);
      el[3] <= 1'b0;
      ec[3] <= 1'b0;
      em[3] <= 1'b1;
      @(posedge mclk);
      em[3] <= 1'b0;
      rc(8'h7a, 8'h0e);
      rc(8'h7b, 8'h02);
      rc(8'h7a, 8'h00);
      rc(8'h7b, 8'h00);
      @(posedge mclk);
      es[3] <= 1'b1;
      repeat (260) @(posedge mclk);
      es[3] <= 1'b0;
      rc(8'h7b, 8'hff);
      rc(8'h7a, 8'h01);
      fork
         rc(8'h7a, 8'h00);
         begin
            @(posedge mclk);
            ec[3] <= 1'b1;
            @(posedge mclk);
            ec[3] <= 1'b0;
         end
      join
      rc(8'h7a, 8'h04);
      rc(8'h7a, 8'h00);
      fork
         rc(8'h7b, 8'h01);
         begin
            @(posedge mclk);
            es[3] <= 1'b1;
            @(posedge mclk);
            es[3] <= 1'b0;
         end
      join
      rc(8'h7b, 8'h01);
      rc(8'h7b, 8'h00);
      $display("error flag test done");
      end_of_test;
   end
endmodule
